/* File: shared/mgu_pkg.sv */
// Package for the memory guard unit: map layout, direct-control codes, sizes.
// Assumes a 16-bit word-addressed memory of up to 64K words.
package mgu_pkg;
  localparam int MGU_NUM_MAPS = 16;
  localparam int MGU_MAP_W = 16;
  localparam int MGU_BLOCK_WORDS = 256;
  localparam int MGU_ADDR_W = 16;
  localparam int MGU_BLOCK_SHIFT = 8;
  localparam int MGU_BANK_WORDS = 8192;
  localparam int MGU_MAX_BANKS = 8;
  localparam logic [3:0] MGU_FN_MAP_LOAD = 4'h8;
  localparam logic [15:0] MGU_MAP_RESET = 16'h0000;
  localparam logic [3:0] MGU_BANKS_RESET = 4'h8;

  // One fetch or operand access request from the sequencer
  typedef struct packed {
    logic        fetch;
    logic        store;
    logic [15:0] addr;
    logic        priv;
    logic        intr_fetch;
  } mgu_req_type;

  // Direct-control write carrying a function code and accumulator value
  typedef struct packed {
    logic        valid;
    logic [7:0]  func;
    logic [15:0] data;
  } mgu_dcw_type;
endpackage

/* File: core/mgu_memory_guard_unit.sv */
// Memory guard unit: block protection map and access checks per request.
// Assumes the sequencer presents one request per cycle, same clock domain.
`timescale 1ns/1ps
module mgu_memory_guard_unit
  import mgu_pkg::*;
#(
  parameter logic [3:0] MEM_BANKS = MGU_BANKS_RESET
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Panel and interrupt state
  input wire logic key_protect_en,
  input wire logic power_on_active,
  // Sequencer request and direct-control write
  input wire mgu_req_type req,
  input wire mgu_dcw_type dcw,
  // Results
  output logic access_ok,
  output logic [15:0] mem_addr,
  output logic violation_pulse,
  output logic machine_fault_pulse,
  output logic protected_program_flag
);

  logic [MGU_MAP_W-1:0] map_r [MGU_NUM_MAPS];
  logic [MGU_MAP_W-1:0] map_nxt [MGU_NUM_MAPS];
  logic prev_prot_r, prev_prot_nxt;
  logic pp_r, pp_nxt;
  logic viol_r, viol_nxt;
  logic mfault_r, mfault_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic checks_on, blk_prot, exists, priv_bad, trans_bad, store_bad;

  // Protection of a block by address
  function automatic logic blk_is_prot(input logic [15:0] a,
                                       input logic [MGU_MAP_W-1:0] m [MGU_NUM_MAPS]);
    return m[a[15:12]][a[11:8]];
  endfunction

  function automatic logic addr_exists(input logic [15:0] a);
    return ({1'b0, a[15:13]} < MEM_BANKS) || (MEM_BANKS >= 4'(MGU_MAX_BANKS));
  endfunction

  always_comb begin
    checks_on = key_protect_en && !power_on_active;
    blk_prot = blk_is_prot(req.addr, map_r);
    exists = addr_exists(req.addr);
    // privileged from unprotected; caller clears priv for exempt ops
    priv_bad = checks_on && req.fetch && req.priv && !blk_prot;
    trans_bad = checks_on && req.fetch && blk_prot && !prev_prot_r && !req.intr_fetch;
    store_bad = checks_on && req.store && blk_prot && !pp_r;
  end

  always_comb begin
    for (int i = 0; i < MGU_NUM_MAPS; i++) begin
      map_nxt[i] = map_r[i];
    end
    if (dcw.valid && dcw.func[7:4] == MGU_FN_MAP_LOAD) begin
      map_nxt[dcw.func[3:0]] = dcw.data;
    end
  end

  always_comb begin
    prev_prot_nxt = prev_prot_r;
    pp_nxt = pp_r;
    viol_nxt = 1'b0;
    mfault_nxt = 1'b0;
    addr_nxt = req.addr;
    if ((req.fetch || req.store) && !exists) begin
      mfault_nxt = 1'b1;
    end else if (priv_bad || trans_bad || store_bad) begin
      viol_nxt = 1'b1;
    end else if (req.fetch) begin
      prev_prot_nxt = blk_prot;
      pp_nxt = blk_prot;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < MGU_NUM_MAPS; i++) begin
        map_r[i] <= MGU_MAP_RESET;
      end
      prev_prot_r <= 1'b0;
      pp_r <= 1'b0;
      viol_r <= 1'b0;
      mfault_r <= 1'b0;
      addr_r <= 16'h0000;
    end else begin
      map_r <= map_nxt;
      prev_prot_r <= prev_prot_nxt;
      pp_r <= pp_nxt;
      viol_r <= viol_nxt;
      mfault_r <= mfault_nxt;
      addr_r <= addr_nxt;
    end
  end

  // Grant is combinational so the sequencer can suppress the access itself
  assign access_ok = (req.fetch || req.store) && exists && !priv_bad && !trans_bad && !store_bad;
  assign mem_addr = addr_r;
  assign violation_pulse = viol_r;
  assign machine_fault_pulse = mfault_r;
  assign protected_program_flag = pp_r;

  property p_priv_viol;
    @(posedge ref_clk) disable iff (sys_rst)
      (priv_bad && exists) |=> violation_pulse;
  endproperty
  a_priv_viol: assert property (p_priv_viol) else $error("privileged op not flagged");

  property p_trans;
    @(posedge ref_clk) disable iff (sys_rst)
      (key_protect_en && !power_on_active && req.fetch && exists && blk_prot
       && !prev_prot_r && !req.intr_fetch) |-> !access_ok ##1 violation_pulse;
  endproperty
  a_trans: assert property (p_trans) else $error("transition not blocked");

  property p_store;
    @(posedge ref_clk) disable iff (sys_rst)
      (key_protect_en && !power_on_active && req.store && exists && blk_prot && !pp_r)
      |-> !access_ok;
  endproperty
  a_store: assert property (p_store) else $error("store not blocked");

  property p_key_off;
    @(posedge ref_clk) disable iff (sys_rst)
      (!key_protect_en && req.fetch && exists) |-> access_ok ##1 !violation_pulse;
  endproperty
  a_key_off: assert property (p_key_off) else $error("check active with key off");

  property p_power_on;
    @(posedge ref_clk) disable iff (sys_rst)
      (power_on_active && req.store && exists) |-> access_ok;
  endproperty
  a_power_on: assert property (p_power_on) else $error("check active at power-on");

  property p_fault;
    @(posedge ref_clk) disable iff (sys_rst)
      ((req.fetch || req.store) && !exists) |-> !access_ok ##1 machine_fault_pulse;
  endproperty
  a_fault: assert property (p_fault) else $error("missing machine fault");

  property p_pulse;
    @(posedge ref_clk) disable iff (sys_rst)
      violation_pulse && !$past(priv_bad || trans_bad || store_bad) |-> 1'b0;
  endproperty
  a_pulse: assert property (p_pulse) else $error("spurious violation");

  property p_map_load;
    @(posedge ref_clk) disable iff (sys_rst)
      (dcw.valid && dcw.func == 8'h8f) |=> map_r[15] == $past(dcw.data);
  endproperty
  a_map_load: assert property (p_map_load) else $error("map not loaded");

  property p_pp;
    @(posedge ref_clk) disable iff (sys_rst)
      (req.fetch && access_ok) |=> protected_program_flag == $past(blk_prot);
  endproperty
  a_pp: assert property (p_pp) else $error("flag not tracking fetch");

  property p_fault_cause;
    @(posedge ref_clk) disable iff (sys_rst)
      machine_fault_pulse |-> $past((req.fetch || req.store) && !exists);
  endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("spurious fault");

  property p_excl;
    @(posedge ref_clk) disable iff (sys_rst)
      !(violation_pulse && machine_fault_pulse);
  endproperty
  a_excl: assert property (p_excl) else $error("fault and violation together");

  property p_addr_copy;
    @(posedge ref_clk) disable iff (sys_rst)
      (req.fetch || req.store) |=> mem_addr == $past(req.addr);
  endproperty
  a_addr_copy: assert property (p_addr_copy) else $error("address not copied");

  property p_prev_hold;
    @(posedge ref_clk) disable iff (sys_rst)
      (req.fetch && !access_ok) |=> prev_prot_r == $past(prev_prot_r);
  endproperty
  a_prev_hold: assert property (p_prev_hold) else $error("record moved on refusal");

  property p_prev_upd;
    @(posedge ref_clk) disable iff (sys_rst)
      (req.fetch && access_ok) |=> prev_prot_r == $past(blk_prot);
  endproperty
  a_prev_upd: assert property (p_prev_upd) else $error("record not updated");

  property p_store_ok;
    @(posedge ref_clk) disable iff (sys_rst)
      (req.store && !req.fetch && exists && pp_r) |-> access_ok;
  endproperty
  a_store_ok: assert property (p_store_ok) else $error("protected store refused");

  property p_unprot_store;
    @(posedge ref_clk) disable iff (sys_rst)
      (req.store && !req.fetch && exists && !blk_prot) |-> access_ok;
  endproperty
  a_unprot_store: assert property (p_unprot_store) else $error("open store refused");

  property p_key_off_store;
    @(posedge ref_clk) disable iff (sys_rst)
      (!key_protect_en && req.store && !req.fetch && exists) |-> access_ok;
  endproperty
  a_key_off_store: assert property (p_key_off_store) else $error("store checked, key off");

  property p_power_fetch;
    @(posedge ref_clk) disable iff (sys_rst)
      (power_on_active && req.fetch && exists) |-> access_ok;
  endproperty
  a_power_fetch: assert property (p_power_fetch) else $error("fetch checked at power-on");

  property p_unpriv;
    @(posedge ref_clk) disable iff (sys_rst)
      (req.fetch && !req.priv && exists && !blk_prot) |-> access_ok;
  endproperty
  a_unpriv: assert property (p_unpriv) else $error("unprivileged fetch refused");

  property p_intr_ok;
    @(posedge ref_clk) disable iff (sys_rst)
      (req.fetch && req.intr_fetch && exists && blk_prot) |-> access_ok;
  endproperty
  a_intr_ok: assert property (p_intr_ok) else $error("interrupt fetch refused");

  property p_pp_hold;
    @(posedge ref_clk) disable iff (sys_rst)
      !req.fetch |=> protected_program_flag == $past(protected_program_flag);
  endproperty
  a_pp_hold: assert property (p_pp_hold) else $error("flag moved without fetch");

  property p_map_keep;
    @(posedge ref_clk) disable iff (sys_rst)
      !(dcw.valid && dcw.func[7:4] == MGU_FN_MAP_LOAD) |=> map_r[0] == $past(map_r[0]);
  endproperty
  a_map_keep: assert property (p_map_keep) else $error("map changed without load");

  property p_no_req;
    @(posedge ref_clk) disable iff (sys_rst)
      !(req.fetch || req.store) |-> !access_ok;
  endproperty
  a_no_req: assert property (p_no_req) else $error("grant without request");

  c_viol: cover property (@(posedge ref_clk) violation_pulse);
  c_fault: cover property (@(posedge ref_clk) machine_fault_pulse);
  c_intr: cover property (@(posedge ref_clk) req.intr_fetch && blk_prot && !prev_prot_r);
  c_load: cover property (@(posedge ref_clk) dcw.valid && dcw.func[7:4] == 4'h8);
endmodule

/* File: testbench/mgu_seq_model.sv */
// Sequencer model: fetches, stores and direct-control map loads.
// Assumes the bench calls go once per cycle; one request per call.
`timescale 1ns/1ps
module mgu_seq_model
  import mgu_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Requests to the guard
  output mgu_req_type req,
  output mgu_dcw_type dcw
);
  initial begin
    req = '0;
    dcw = '0;
  end

  // k is fetch, store, privileged, interrupt answer; fn nonzero sends a direct-control write, and fn 8x loads map x
  // map load, heads unprivileged
  task automatic go(input logic [3:0] k, input logic [15:0] a, input logic [7:0] fn);
    @(posedge ref_clk);
    req <= '{fetch: k[3], store: k[2], addr: a, priv: k[1], intr_fetch: k[0]};
    dcw <= '{valid: fn != 8'h00, func: fn, data: a};
  endtask
endmodule

/* File: testbench/mgu_memory_guard_unit_tb.sv */
// Bench for the guard unit: map loads, violations, faults, key override.
// Assumes seven 8K banks installed, so the top bank faults.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("mismatch %0t %h %h", $time, a, b); end end
module mgu_memory_guard_unit_tb
  import mgu_pkg::*;
;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic key_en = 1'b1;
  logic pwr_on = 1'b0;
  mgu_req_type req;
  mgu_dcw_type dcw;
  logic access_ok, violation_pulse, machine_fault_pulse, pp_flag;
  logic [15:0] mem_addr;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;

  always #2.5 ref_clk = ~ref_clk;

  mgu_seq_model seq_u (.ref_clk(ref_clk), .req(req), .dcw(dcw));
  mgu_memory_guard_unit #(.MEM_BANKS(4'h7)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .key_protect_en(key_en), .power_on_active(pwr_on), .req(req), .dcw(dcw),
    .access_ok(access_ok), .mem_addr(mem_addr), .violation_pulse(violation_pulse),
    .machine_fault_pulse(machine_fault_pulse), .protected_program_flag(pp_flag));

  // Expected e is access_ok, violation, fault
  task automatic step(input logic [3:0] k, input logic [15:0] a, input logic [2:0] e);
    seq_u.go(k, a, 8'h00);
    #1;
    `CHK(access_ok, e[2])
    seq_u.go(4'h0, 16'h0000, 8'h00);
    #1;
    `CHK({violation_pulse, machine_fault_pulse}, e[1:0])
    `CHK(mem_addr, a)
  endtask

  task automatic t_store;
    seq_u.go(4'h0, 16'h0002, 8'h80);
    seq_u.go(4'h0, 16'h0001, 8'h81);
    step(4'h8, 16'h0000, 3'b100);
    step(4'h4, 16'h0100, 3'b010);
    step(4'h4, 16'h0200, 3'b100);
    step(4'h4, 16'h1000, 3'b010);
  endtask

  task automatic t_priv;
    step(4'ha, 16'h0000, 3'b010);
    step(4'h8, 16'h0000, 3'b100);
  endtask

  task automatic t_cross;
    step(4'h8, 16'h00ff, 3'b100);
    step(4'h8, 16'h0100, 3'b010);
    step(4'h9, 16'h0100, 3'b100);
    `CHK(pp_flag, 1'b1)
    step(4'h4, 16'h0100, 3'b100);
  endtask

  task automatic t_off;
    step(4'h8, 16'h0000, 3'b100);
    `CHK(pp_flag, 1'b0)
    @(posedge ref_clk) key_en <= 1'b0;
    step(4'h8, 16'h0100, 3'b100);
    step(4'ha, 16'h0000, 3'b100);
    @(posedge ref_clk) key_en <= 1'b1;
    pwr_on <= 1'b1;
    step(4'h8, 16'h0100, 3'b100);
    @(posedge ref_clk) pwr_on <= 1'b0;
  endtask

  task automatic t_fault;
    step(4'h8, 16'he000, 3'b001);
    step(4'h4, 16'hdfff, 3'b100);
  endtask

  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_store();
    t_priv();
    t_cross();
    t_off();
    t_fault();
    summarize();
  end
endmodule
